/* File: verif/nvm_array_model.sv */
`timescale 1ns/100ps
// Array and key store behind the sequencer: verify result and stored key words
module nvm_array_model (
  // Key lookup
  input  wire logic [15:0] key_addr,
  output logic      [15:0] key_data,
  // Verify result, steered by the bench
  input  wire logic        fail_verify,
  input  wire logic        fail_unc,
  output logic             verify_error,
  output logic             verify_uncorrectable
);
  // Verify result reported as the bench commands it
  assign verify_error         = fail_verify;
  assign verify_uncorrectable = fail_unc;
  // Stored keys at 0xff70 upward, one word per key; elsewhere nothing matches
  assign key_data = (key_addr[15:3] == 13'h1fee && !key_addr[0])
                  ? {8'h40 + {6'h00, key_addr[2:1]}, 8'h21 + {6'h00, key_addr[2:1]}}
                  : 16'h0000;
endmodule

/* File: verif/nvm_erase_security_sva.sv */
`timescale 1ns/100ps
module nvm_erase_security_sva
  import nvm_cmd_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Register port
  input wire logic [3:0]  reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_write,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  // Array and key side
  input wire logic        array_erase,
  input wire logic        array_select_ee,
  input wire logic        array_erase_all,
  input wire logic [6:0]  array_sector,
  input wire logic        verify_error,
  input wire logic        verify_uncorrectable,
  input wire logic [15:0] key_addr,
  input wire logic [15:0] key_data,
  input wire logic        secure_released
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  logic        launch_w;     // Launch write seen on the port
  logic [15:0] erase_len;    // Cycles the current erase has lasted
  logic [3:0]  since_launch; // Age of the last launch, saturating
  assign launch_w = reg_write && reg_addr == ADDR_STATUS && reg_wdata[STAT_CCF];

  // Erase timer, cleared between erases so each is timed alone
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) erase_len <= 16'h0000;
    else if (array_erase) erase_len <= erase_len + 16'h0001;
    else erase_len <= 16'h0000;
  end

  // Launch age; saturates so long idle stretches never wrap
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) since_launch <= 4'hf;
    else if (launch_w) since_launch <= 4'h0;
    else if (since_launch != 4'hf) since_launch <= since_launch + 4'h1;
  end

  property p_erase_min; $rose(array_erase) |-> array_erase [*8]; endproperty
  a_erase_min: assert property (p_erase_min) else $error("erase too short");
  property p_erase_len; $fell(array_erase) |-> erase_len == ERASE_CYCLES; endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
  property p_erase_stable;
    array_erase && $past(array_erase) |-> $stable(array_select_ee) && $stable(array_erase_all) && $stable(array_sector);
  endproperty
  a_erase_stable: assert property (p_erase_stable) else $error("target moved in erase");
  property p_erase_cause; $rose(array_erase) |-> since_launch inside {[4'h1:4'h4]}; endproperty
  a_erase_cause: assert property (p_erase_cause) else $error("erase without launch");
  property p_busy_status; $past(reg_read && reg_addr == ADDR_STATUS && array_erase) |-> !reg_rdata[STAT_CCF]; endproperty
  a_busy_status: assert property (p_busy_status) else $error("complete during erase");
  property p_launch_clears;
    $past(reg_read && reg_addr == ADDR_STATUS && since_launch inside {4'h1, 4'h2}) |-> !reg_rdata[STAT_CCF];
  endproperty
  a_launch_clears: assert property (p_launch_clears) else $error("complete not cleared");
  // Release only right after a clean unsecure verify or the last key compare
  property p_sec_rise;
    $rose(secure_released) |-> $past(array_erase_all && !verify_error && !verify_uncorrectable)
      && $past(array_erase, 2) || $past(key_addr) == KEY_BASE_ADDR + 16'h0006;
  endproperty
  a_sec_rise: assert property (p_sec_rise) else $error("security released without cause");
  property p_rdata_idle; !$past(reg_read) |-> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
endmodule

bind nvm_erase_security nvm_erase_security_sva u_sva (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_write,
  .reg_read, .reg_rdata, .array_erase, .array_select_ee, .array_erase_all, .array_sector, .verify_error,
  .verify_uncorrectable, .key_addr, .key_data, .secure_released);

/* File: verif/nvm_erase_security_tb.sv */
`timescale 1ns/100ps
module nvm_erase_security_tb;
  import nvm_cmd_pkg::*;

  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic [7:0]  reg_rdata, d;
  logic        array_erase, array_select_ee, array_erase_all, secure_released;
  logic        verify_error, verify_uncorrectable, sel_seen, all_seen;
  logic [6:0]  array_sector, sec_seen;
  logic [15:0] key_addr, key_data;
  logic        fail_verify = 1'b0;
  logic        fail_unc = 1'b0;
  int          erase_cnt = 0;     // Cycles the array has been told to erase
  int          error_cnt = 0, num_checks = 0, cycles = 0;

  nvm_erase_security dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .array_erase, .array_select_ee, .array_erase_all, .array_sector, .verify_error, .verify_uncorrectable,
    .key_addr, .key_data, .secure_released);
  nvm_array_model model (.key_addr, .key_data, .fail_verify, .fail_unc, .verify_error, .verify_uncorrectable);

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard: a whole run needs five erases at most
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      stop_test();
    end
  end

  // Remember what the array was told during the last erase
  always @(posedge clk_sys) begin
    if (array_erase === 1'b1) begin
      erase_cnt  <= erase_cnt + 1;
      sel_seen   <= array_select_ee;
      all_seen   <= array_erase_all;
      sec_seen   <= array_sector;
    end
  end

  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic ld(input logic [2:0] i, input logic [7:0] h, input logic [7:0] l);
    wr(ADDR_INDEX, {5'h00, i});
    wr(ADDR_WORD_HIGH, h);
    wr(ADDR_WORD_LOW, l);
  endtask

  // Launch, then only read until complete: no writes while a command runs
  task automatic go(input logic [7:0] st, input logic er);
    int e0;
    e0 = erase_cnt;
    wr(ADDR_STATUS, 8'h80);
    repeat (3000) begin
      rd(ADDR_STATUS);
      if (d[STAT_CCF] === 1'b1) break;
    end
    chk("status", st, d);
    chk("erase_seen", {7'h00, er}, {7'h00, erase_cnt != e0});
    if (er) chk("erase_len", 8'h01, {7'h00, (erase_cnt - e0) == int'(ERASE_CYCLES)});
  endtask

  task automatic cmd(input logic [7:0] c, input logic [7:0] blk, input logic [15:0] a,
                     input logic [2:0] last, input logic [7:0] st, input logic er);
    ld(3'h0, c, blk);
    if (last != 3'h0) ld(3'h1, a[15:8], a[7:0]);
    wr(ADDR_INDEX, {5'h00, last});
    go(st, er);
  endtask

  task automatic key(input logic bad, input logic [2:0] last, input logic [7:0] st);
    ld(3'h0, CMD_VERIFY_KEY, 8'h00);
    for (int k = 0; k < 4; k++) ld(3'(k + 1), 8'h40 + 8'(k), (bad && k == 3) ? 8'h00 : 8'h21 + 8'(k));
    wr(ADDR_INDEX, {5'h00, last});
    go(st, 1'b0);
  endtask

  task automatic t_erase();
    cmd(CMD_ERASE_BLOCK, 8'h80, 16'h0000, 3'h1, 8'h80, 1'b1);
    chk("select_ee", 8'h01, {7'h00, sel_seen});
    chk("erase_all", 8'h00, {7'h00, all_seen});
  endtask

  task automatic t_errors();
    cmd(CMD_ERASE_BLOCK, 8'h00, 16'h0000, 3'h0, 8'ha0, 1'b0);
    cmd(CMD_ERASE_SECTOR, 8'h00, 16'h1000, 3'h2, 8'ha0, 1'b0);
    cmd(CMD_ERASE_BLOCK, 8'h01, 16'h0000, 3'h1, 8'ha0, 1'b0);
    cmd(CMD_ERASE_SECTOR, 8'h7f, 16'h1000, 3'h1, 8'ha0, 1'b0);
    cmd(CMD_ERASE_SECTOR, 8'h00, 16'h1001, 3'h1, 8'ha0, 1'b0);
    cmd(CMD_ERASE_SECTOR, 8'h00, 16'h1002, 3'h1, 8'ha0, 1'b0);
    cmd(CMD_UNSECURE, 8'h00, 16'h0000, 3'h1, 8'ha0, 1'b0);
    wr(ADDR_MODE, 8'h00);
    cmd(CMD_ERASE_BLOCK, 8'h00, 16'h0000, 3'h1, 8'ha0, 1'b0);
    cmd(CMD_UNSECURE, 8'h00, 16'h0000, 3'h0, 8'ha0, 1'b0);
    wr(ADDR_MODE, 8'h01);
  endtask

  task automatic t_protect();
    wr(ADDR_PROTECT, 8'h01);
    cmd(CMD_ERASE_BLOCK, 8'h00, 16'h0000, 3'h1, 8'h90, 1'b0);
    cmd(CMD_UNSECURE, 8'h00, 16'h0000, 3'h0, 8'h90, 1'b0);
    wr(ADDR_PROTECT, 8'h02);
    cmd(CMD_ERASE_BLOCK, 8'h80, 16'h0000, 3'h1, 8'h90, 1'b0);
    cmd(CMD_UNSECURE, 8'h00, 16'h0000, 3'h0, 8'h90, 1'b0);
    wr(ADDR_PROTECT, 8'h04);
    cmd(CMD_ERASE_SECTOR, 8'h00, 16'h0e00, 3'h1, 8'h90, 1'b0);
    cmd(CMD_ERASE_SECTOR, 8'h00, 16'h1000, 3'h1, 8'h80, 1'b1);
    chk("sector", 8'h08, {1'b0, sec_seen});
    wr(ADDR_PROTECT, 8'h00);
  endtask

  task automatic t_verify();
    fail_verify <= 1'b1;
    fail_unc    <= 1'b1;
    cmd(CMD_ERASE_BLOCK, 8'h00, 16'h0000, 3'h1, 8'h83, 1'b1);
    chk("select_ee", 8'h00, {7'h00, sel_seen});
    fail_unc <= 1'b0;
    cmd(CMD_UNSECURE, 8'h00, 16'h0000, 3'h0, 8'h82, 1'b1);
    chk("released", 8'h00, {7'h00, secure_released});
    chk("erase_all", 8'h01, {7'h00, all_seen});
    fail_verify <= 1'b0;
    cmd(CMD_UNSECURE, 8'h00, 16'h0000, 3'h0, 8'h80, 1'b1);
    chk("released", 8'h01, {7'h00, secure_released});
  endtask

  // Mid-run reset, so security and the key lock start clean
  task automatic rst();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask

  // A release is never taken back by a mismatch, so the bad key runs after a reset
  task automatic t_key();
    rst();
    key(1'b0, 3'h4, 8'ha0);
    wr(ADDR_SECURITY, 8'h80);
    key(1'b0, 3'h3, 8'ha0);
    key(1'b0, 3'h4, 8'h80);
    chk("released", 8'h01, {7'h00, secure_released});
    rst();
    chk("released", 8'h00, {7'h00, secure_released});
    rd(ADDR_STATUS);
    chk("status_reset", 8'h80, d);
    wr(ADDR_SECURITY, 8'h80);
    key(1'b1, 3'h4, 8'ha0);
    chk("released", 8'h00, {7'h00, secure_released});
    key(1'b0, 3'h4, 8'ha0);
    chk("released", 8'h00, {7'h00, secure_released});
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(ADDR_STATUS);
    chk("status_reset", 8'h80, d);
    t_erase();
    t_errors();
    t_protect();
    t_verify();
    t_key();
    stop_test();
  end
endmodule

/* File: verilog/nvm_cmd_pkg.sv */
package nvm_cmd_pkg;

  // Command codes held in the high byte of parameter word 0
  localparam logic [7:0] CMD_ERASE_BLOCK  = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0a;
  localparam logic [7:0] CMD_UNSECURE     = 8'h0b;
  localparam logic [7:0] CMD_VERIFY_KEY   = 8'h0c;

  // Parameter word index that each command must end on
  localparam logic [2:0] IDX_ERASE_LAST   = 3'h1;
  localparam logic [2:0] IDX_UNSECURE     = 3'h0;
  localparam logic [2:0] IDX_KEY_LAST     = 3'h4;
  localparam int         NUM_WORDS        = 6;

  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_INDEX       = 4'h0;
  localparam logic [3:0] ADDR_WORD_HIGH   = 4'h1;
  localparam logic [3:0] ADDR_WORD_LOW    = 4'h2;
  localparam logic [3:0] ADDR_STATUS      = 4'h3;
  localparam logic [3:0] ADDR_SECURITY    = 4'h4;
  localparam logic [3:0] ADDR_PROTECT     = 4'h5;
  localparam logic [3:0] ADDR_MODE        = 4'h6;

  // Status register bit positions
  localparam int         STAT_CCF         = 7;
  localparam int         STAT_ACC         = 5;
  localparam int         STAT_PROT        = 4;
  localparam int         STAT_VERR        = 1;
  localparam int         STAT_VUNC        = 0;

  // Security register fields
  localparam int         SEC_BACKDOOR_KEY_ENABLE_FIELD_LSB    = 6;
  localparam logic [1:0] BACKDOOR_KEY_ENABLE_FIELD_ENABLED    = 2'h2;
  localparam logic [1:0] SEC_UNSECURED    = 2'h2;
  localparam logic [7:0] SECURITY_RESET   = 8'h00;

  // Address layout: block select byte, sector field and key store base
  localparam int         BLOCK_SEL_BIT    = 7;
  localparam logic [6:0] BLOCK_ID_VALID   = 7'h00;
  localparam int         SECTOR_LSB       = 9;
  localparam logic [15:0] KEY_BASE_ADDR   = 16'hff70;

  // Protection register bits: flash, EEPROM, sector fields
  localparam int         PROT_FLASH_ALL   = 0;
  localparam int         PROT_EE_ALL      = 1;
  localparam int         PROT_LOW_SECTORS = 2;
  localparam logic [6:0] PROT_SECTOR_LIM  = 7'h08;

  // Mode register bit: high allows erase commands in this mode
  localparam int         MODE_ERASE_OK    = 0;

  // Timing of array operations; erase time converted to cycles of clk_sys
  localparam int         CLK_MHZ          = 100;
  localparam int         ERASE_TIME_US    = 20;
  localparam logic [15:0] ERASE_CYCLES    = 16'(ERASE_TIME_US * CLK_MHZ);

  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_CHECK  = 6'b000010,
    ST_ERASE  = 6'b000100,
    ST_VERIFY = 6'b001000,
    ST_KEY    = 6'b010000,
    ST_DONE   = 6'b100000
  } seq_state_t;

endpackage

/* File: verilog/nvm_erase_security.sv */
`timescale 1ns/100ps
module nvm_erase_security
  import nvm_cmd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  // Array interface: erase request and verify result
  output logic             array_erase,
  output logic             array_select_ee,
  output logic             array_erase_all,
  output logic      [6:0]  array_sector,
  input  wire logic        verify_error,
  input  wire logic        verify_uncorrectable,
  // Stored backdoor comparison key lookup
  output logic      [15:0] key_addr,
  input  wire logic [15:0] key_data,
  // Security state seen by the rest of the chip
  output logic             secure_released
);

  logic [2:0]  command_word_index;     // Parameter word index
  logic [15:0] command_parameter_words [NUM_WORDS]; // Parameter words
  logic        command_complete_flag;  // High while idle
  logic        access_error_flag;      // Sticky access error
  logic        protection_violation_flag; // Sticky protection error
  logic        verify_error_flag;      // Verify saw an error
  logic        verify_uncorrectable_flag; // Verify saw uncorrectable error
  logic [7:0]  security_config_reg;    // Security and key enable
  logic [7:0]  protect_reg;            // Protection settings
  logic [7:0]  mode_reg;               // Operating mode permissions
  logic        key_locked_reg;         // Set after a key mismatch
  seq_state_t  state_reg;              // Sequencer state
  logic [15:0] timer_reg;              // Erase duration counter
  logic [2:0]  key_num_reg;            // Key under comparison
  logic        launch;                 // Software cleared complete flag
  logic        err_acc;                // Launch access error found
  logic        err_prot;               // Launch protection error found
  logic [7:0]  cmd_code;               // Command in word 0
  logic [7:0]  blk_byte;               // Address bits 23:16
  logic [15:0] low_addr;               // Address bits 15:0
  logic [7:0]  status_value;           // Packed status register

  // Write of a one to the complete bit launches a command when idle
  function automatic logic reg_hit(input logic [3:0] a, input logic [3:0] off);
    return reg_write && (a == off);
  endfunction

  assign cmd_code = command_parameter_words[0][15:8];
  assign blk_byte = command_parameter_words[0][7:0];
  assign low_addr = command_parameter_words[1];
  assign launch   = reg_hit(reg_addr, ADDR_STATUS) && reg_wdata[STAT_CCF]
                    && command_complete_flag;

  // Launch checks: index, mode, address, enable, lock, protection
  always_comb begin
    err_acc  = 1'b0;
    err_prot = 1'b0;
    case (cmd_code)
      CMD_ERASE_BLOCK, CMD_ERASE_SECTOR: begin
        if (command_word_index != IDX_ERASE_LAST)            err_acc = 1'b1;
        if (!mode_reg[MODE_ERASE_OK])                        err_acc = 1'b1;
        if (blk_byte[BLOCK_SEL_BIT-1:0] != BLOCK_ID_VALID)   err_acc = 1'b1;
        if (cmd_code == CMD_ERASE_SECTOR && low_addr[1:0] != 2'h0) begin
          err_acc = 1'b1;
        end
        if (cmd_code == CMD_ERASE_BLOCK) begin
          // Any protection in the chosen array blocks the block erase
          err_prot = blk_byte[BLOCK_SEL_BIT] ? protect_reg[PROT_EE_ALL]
                   : (protect_reg[PROT_FLASH_ALL] || protect_reg[PROT_LOW_SECTORS]);
        end else begin
          err_prot = blk_byte[BLOCK_SEL_BIT] ? protect_reg[PROT_EE_ALL]
                   : (protect_reg[PROT_FLASH_ALL] || (protect_reg[PROT_LOW_SECTORS]
                      && low_addr[15:SECTOR_LSB] < PROT_SECTOR_LIM));
        end
      end
      CMD_UNSECURE: begin
        if (command_word_index != IDX_UNSECURE) err_acc = 1'b1;
        if (!mode_reg[MODE_ERASE_OK])           err_acc = 1'b1;
        err_prot = protect_reg[PROT_FLASH_ALL] || protect_reg[PROT_EE_ALL]
                   || protect_reg[PROT_LOW_SECTORS];
      end
      CMD_VERIFY_KEY: begin
        if (command_word_index != IDX_KEY_LAST) err_acc = 1'b1;
        if (security_config_reg[SEC_BACKDOOR_KEY_ENABLE_FIELD_LSB +: 2] != BACKDOOR_KEY_ENABLE_FIELD_ENABLED) err_acc = 1'b1;
        if (key_locked_reg)                     err_acc = 1'b1;
      end
      default: err_acc = 1'b1; // Codes outside this block are refused
    endcase
  end

  // Index register and parameter words; writes ignored while busy
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      command_word_index <= 3'h0;
      for (int i = 0; i < NUM_WORDS; i++) begin
        command_parameter_words[i] <= 16'h0000;
      end
    end else if (command_complete_flag) begin
      if (reg_hit(reg_addr, ADDR_INDEX)) begin
        command_word_index <= reg_wdata[2:0];
      end
      // Out of range indexes 6 and 7 write nothing, saving two words
      if (reg_hit(reg_addr, ADDR_WORD_HIGH) && command_word_index < 3'(NUM_WORDS)) begin
        command_parameter_words[command_word_index][15:8] <= reg_wdata;
      end
      if (reg_hit(reg_addr, ADDR_WORD_LOW) && command_word_index < 3'(NUM_WORDS)) begin
        command_parameter_words[command_word_index][7:0] <= reg_wdata;
      end
    end
  end

  // Configuration registers, held while a command runs
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      protect_reg <= 8'h00;
      mode_reg    <= 8'h01;
    end else if (command_complete_flag) begin
      if (reg_hit(reg_addr, ADDR_PROTECT)) begin
        protect_reg <= reg_wdata;
      end
      if (reg_hit(reg_addr, ADDR_MODE)) begin
        mode_reg <= reg_wdata;
      end
    end
  end

  // Sequencer: check, erase, verify or compare keys, then complete
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= ST_IDLE;
      timer_reg   <= 16'h0000;
      key_num_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (launch) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          timer_reg   <= ERASE_CYCLES;
          key_num_reg <= 3'h0;
          if (err_acc || err_prot) begin
            state_reg <= ST_DONE;
          end else if (cmd_code == CMD_VERIFY_KEY) begin
            state_reg <= ST_KEY;
          end else begin
            state_reg <= ST_ERASE;
          end
        end
        ST_ERASE: begin
          // Erase pulse holds for the programmed time
          if (timer_reg == 16'h0001) begin
            state_reg <= ST_VERIFY;
          end else begin
            timer_reg <= timer_reg - 16'h0001;
          end
        end
        ST_VERIFY: state_reg <= ST_DONE;
        ST_KEY: begin
          // Key number advances one per cycle; mismatch ends early
          if (key_data != command_parameter_words[3'(key_num_reg + 3'h1)]
              || key_num_reg == 3'h3) begin
            state_reg <= ST_DONE;
          end else begin
            key_num_reg <= key_num_reg + 3'h1;
          end
        end
        ST_DONE: state_reg <= ST_IDLE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Status flags; a new launch clears errors of the previous command
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      command_complete_flag     <= 1'b1;
      access_error_flag         <= 1'b0;
      protection_violation_flag <= 1'b0;
      verify_error_flag         <= 1'b0;
      verify_uncorrectable_flag <= 1'b0;
    end else begin
      if (launch) begin
        command_complete_flag     <= 1'b0;
        access_error_flag         <= 1'b0;
        protection_violation_flag <= 1'b0;
        verify_error_flag         <= 1'b0;
        verify_uncorrectable_flag <= 1'b0;
      end else if (state_reg == ST_DONE) begin
        command_complete_flag <= 1'b1;
      end
      if (state_reg == ST_CHECK) begin
        access_error_flag         <= err_acc;
        protection_violation_flag <= err_prot;
      end
      if (state_reg == ST_KEY && key_data != command_parameter_words[3'(key_num_reg + 3'h1)]) begin
        access_error_flag <= 1'b1;
      end
      if (state_reg == ST_VERIFY) begin
        verify_error_flag         <= verify_error;
        verify_uncorrectable_flag <= verify_uncorrectable;
      end
    end
  end

  // Security state and key lock
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      security_config_reg <= SECURITY_RESET;
      key_locked_reg      <= 1'b0;
    end else begin
      if (reg_hit(reg_addr, ADDR_SECURITY) && command_complete_flag) begin
        // Only the key enable field is software loaded here
        security_config_reg[SEC_BACKDOOR_KEY_ENABLE_FIELD_LSB +: 2] <= reg_wdata[SEC_BACKDOOR_KEY_ENABLE_FIELD_LSB +: 2];
      end
      if (state_reg == ST_VERIFY && cmd_code == CMD_UNSECURE && !verify_error
          && !verify_uncorrectable) begin
        security_config_reg[1:0] <= SEC_UNSECURED;
      end
      if (state_reg == ST_KEY) begin
        if (key_data != command_parameter_words[3'(key_num_reg + 3'h1)]) begin
          key_locked_reg <= 1'b1;
        end else if (key_num_reg == 3'h3) begin
          security_config_reg[1:0] <= SEC_UNSECURED;
        end
      end
    end
  end

  // Array drive, address of the stored key word
  always_comb begin
    array_erase     = (state_reg == ST_ERASE);
    array_erase_all = (cmd_code == CMD_UNSECURE);
    array_select_ee = blk_byte[BLOCK_SEL_BIT];
    array_sector    = low_addr[15:SECTOR_LSB];
    key_addr        = KEY_BASE_ADDR + {12'h000, key_num_reg, 1'b0};
    secure_released = (security_config_reg[1:0] == SEC_UNSECURED);
  end

  assign status_value = {command_complete_flag, 1'b0, access_error_flag,
                         protection_violation_flag, 2'b00, verify_error_flag,
                         verify_uncorrectable_flag};

  // Read data, one cycle after the read strobe
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_INDEX:     reg_rdata <= {5'h00, command_word_index};
        ADDR_WORD_HIGH: reg_rdata <= (command_word_index < 3'(NUM_WORDS)) ?
                                     command_parameter_words[command_word_index][15:8] : 8'h00;
        ADDR_WORD_LOW:  reg_rdata <= (command_word_index < 3'(NUM_WORDS)) ?
                                     command_parameter_words[command_word_index][7:0] : 8'h00;
        ADDR_STATUS:    reg_rdata <= status_value;
        ADDR_SECURITY:  reg_rdata <= security_config_reg;
        ADDR_PROTECT:   reg_rdata <= protect_reg;
        ADDR_MODE:      reg_rdata <= mode_reg;
        default:        reg_rdata <= 8'h00; // Unmapped reads zero
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
